// >>> bench/wsg_gear_model.sv
// Behavioural switchgear with two auxiliary contacts and a travel delay
`timescale 1ns/100ps
`default_nettype none
module wsg_gear_model #(
	parameter int DLY = 8
) (
	input wire logic clk_i,
	input wire logic go_closed_i,
	input wire logic go_open_i,
	output logic aux_closed_o,
	output logic aux_open_o
);
	int cnt;
	logic tgt;
	initial begin
		cnt = 0;
		tgt = 1'b0;
		aux_closed_o = 1'b0;
		aux_open_o = 1'b1;
	end
	// Both contacts low in transit, so a stuck travel reads as disturbed
	always @(posedge clk_i) begin
		if (cnt > 1) begin
			cnt <= cnt - 1;
		end else if (cnt == 1) begin
			cnt <= 0;
			aux_closed_o <= tgt;
			aux_open_o <= !tgt;
		end else if ((go_closed_i && !aux_closed_o) || (go_open_i && !aux_open_o)) begin
			tgt <= go_closed_i;
			cnt <= DLY;
			aux_closed_o <= 1'b0;
			aux_open_o <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// >>> bench/wsg_top_monitor.sv
// Bus and position checker bound to the supervision top
`timescale 1ns/100ps
`default_nettype none
module wsg_top_monitor (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [4:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_we_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic [1:0] pos_o,
	input wire logic removed_o,
	input wire logic elem_close_o,
	input wire logic elem_open_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic req;
	logic cmd_wr;
	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign cmd_wr = req && wb_we_i && wb_sel_i[0] && (wb_adr_i == wsg_pkg::REG_CMD);
	property p_ack_next; req |=> wb_ack_o; endproperty
	a_ack_next: assert property (p_ack_next) else $error("ack missing after request");
	property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
	a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
	property p_ack_cause; wb_ack_o |-> $past(req); endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
	property p_removed_open; removed_o [*3] |-> pos_o != wsg_pkg::POS_CLOSED; endproperty
	a_removed_open: assert property (p_removed_open) else $error("closed while removed");
	property p_one_cmd; !(elem_close_o && elem_open_o); endproperty
	a_one_cmd: assert property (p_one_cmd) else $error("close and open together");
	property p_close_indet;
		elem_close_o [*2] |-> pos_o inside {wsg_pkg::POS_INDETERM, wsg_pkg::POS_DISTURB};
	endproperty
	a_close_indet: assert property (p_close_indet) else $error("end position during close");
	property p_open_indet;
		elem_open_o [*2] |-> pos_o inside {wsg_pkg::POS_INDETERM, wsg_pkg::POS_DISTURB};
	endproperty
	a_open_indet: assert property (p_open_indet) else $error("end position during open");
	property p_close_cmd;
		cmd_wr && wb_dat_i[0] && !removed_o && pos_o == wsg_pkg::POS_OPEN |-> ##[2:6] elem_close_o;
	endproperty
	a_close_cmd: assert property (p_close_cmd) else $error("close command not issued");
	property p_open_cmd;
		cmd_wr && wb_dat_i[1] && !wb_dat_i[0] && pos_o == wsg_pkg::POS_CLOSED
			|-> ##[2:6] elem_open_o;
	endproperty
	a_open_cmd: assert property (p_open_cmd) else $error("open command not issued");
	c_close_end: cover property (elem_close_o ##1 !elem_close_o);
	c_open_end: cover property (elem_open_o ##1 !elem_open_o);
	c_removed: cover property (removed_o [*3]);
endmodule
bind wsg_top wsg_top_monitor i_wsg_top_monitor (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
	.wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .pos_o(pos_o), .removed_o(removed_o),
	.elem_close_o(elem_close_o), .elem_open_o(elem_open_o));
`default_nettype wire

// >>> bench/wsg_top_tb_top.sv
// Register-level testbench for the switchgear supervision block
`timescale 1ns/100ps
`default_nettype none
module wsg_top_tb_top;
	logic clk_i, rst_i, cyc, stb, we, ack, rm_in, gnd_in, gop_in, rdy, prc, pro;
	logic [3:0] sel;
	logic removed, ec, eo, ti, to, irq, eac, eao, tac, tao;
	logic [4:0] adr;
	logic [31:0] dw, rd, q;
	logic [1:0] pos, gpos;
	logic [4:0] mon;
	int n_mismatch = 0;
	int checks = 0;
	assign mon = {irq, to, ti, eo, ec};
	wsg_top i_wsg_top (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(dw),
		.wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rd),
		.wb_ack_o(ack), .elem_aux_closed_i(eac), .elem_aux_open_i(eao), .elem_ready_i(rdy),
		.elem_removed_i(rm_in), .truck_aux_closed_i(tac), .truck_aux_open_i(tao),
		.earth_aux_earthed_i(gnd_in), .earth_aux_open_i(gop_in), .prot_close_i(prc),
		.prot_open_i(pro), .pos_o(pos), .removed_o(removed), .earth_pos_o(gpos),
		.elem_close_o(ec), .elem_open_o(eo), .truck_in_o(ti), .truck_out_o(to), .irq_o(irq));
	// Slow element and quick truck exercise both answer speeds
	wsg_gear_model #(.DLY(8)) i_wsg_gear_model (.clk_i(clk_i), .go_closed_i(ec),
		.go_open_i(eo), .aux_closed_o(eac), .aux_open_o(eao));
	wsg_gear_model #(.DLY(3)) i_wsg_gear_model_truck (.clk_i(clk_i), .go_closed_i(ti),
		.go_open_i(to), .aux_closed_o(tac), .aux_open_o(tao));
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	task give_verdict;
		if (n_mismatch == 0 && checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task fail;
		n_mismatch++;
		give_verdict();
	endtask
	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dw <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 50);
		q = rd;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		if (n >= 50) fail();
	endtask
	task wait_bit(input int b, input logic v);
		int n;
		n = 0;
		while (mon[b] !== v && n < 400) begin
			@(posedge clk_i);
			n++;
		end
		if (mon[b] !== v) fail();
	endtask
	task settle;
		repeat (3) @(posedge clk_i);
	endtask
	// One-cycle protection command pulse, same clock as the block
	task pulse_prot(input logic c);
		if (c) prc <= 1'b1;
		else pro <= 1'b1;
		@(posedge clk_i);
		prc <= 1'b0;
		pro <= 1'b0;
	endtask
	initial begin
		{cyc, stb, we, rm_in, gnd_in} = 5'h00;
		adr = 5'h00;
		dw = 32'h0000_0000;
		gop_in = 1'b1;
		{prc, pro} = 2'h0;
		rdy = 1'b1;
		sel = 4'hF;
		rst_i = 1'b1;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (20) @(posedge clk_i);
		bus(1'b0, wsg_pkg::REG_ELEM_TIME, 32'h0); chk("elem_time", 32'h0000_0A0A, q);
		// Write on an unused lane must leave the control bits alone
		sel <= 4'h2;
		bus(1'b1, wsg_pkg::REG_CTRL, 32'h1F);
		sel <= 4'hF;
		bus(1'b0, wsg_pkg::REG_CTRL, 32'h0); chk("ctrl", 32'h0, q);
		chk("pos idle", 32'(wsg_pkg::POS_OPEN), 32'(pos));
		bus(1'b0, wsg_pkg::REG_STATUS, 32'h0); chk("status idle", 32'h0000_02A9, q);
		gnd_in <= 1'b1;
		gop_in <= 1'b0;
		bus(1'b1, wsg_pkg::REG_CMD, 32'h1); wait_bit(0, 1'b1); settle();
		chk("pos closing", 32'(wsg_pkg::POS_INDETERM), 32'(pos));
		wait_bit(0, 1'b0); settle(); chk("pos closed", 32'(wsg_pkg::POS_CLOSED), 32'(pos));
		chk("earth pos", 32'(wsg_pkg::POS_CLOSED), 32'(gpos));
		bus(1'b1, wsg_pkg::REG_CMD, 32'h4); wait_bit(2, 1'b1); wait_bit(2, 1'b0);
		bus(1'b1, wsg_pkg::REG_CTRL, 32'h1);
		// Look while a wrongly issued withdraw pulse would still stand
		bus(1'b1, wsg_pkg::REG_CMD, 32'h8); repeat (3) @(posedge clk_i);
		chk("truck out blocked", 32'h0, 32'(to));
		bus(1'b1, wsg_pkg::REG_CMD, 32'h2); wait_bit(1, 1'b1); settle();
		chk("pos opening", 32'(wsg_pkg::POS_INDETERM), 32'(pos));
		wait_bit(1, 1'b0); settle(); chk("pos opened", 32'(wsg_pkg::POS_OPEN), 32'(pos));
		bus(1'b1, wsg_pkg::REG_CMD, 32'h8); wait_bit(3, 1'b1); wait_bit(3, 1'b0);
		bus(1'b1, wsg_pkg::REG_CMD, 32'h1); wait_bit(0, 1'b1); wait_bit(0, 1'b0);
		pulse_prot(1'b0); repeat (2) @(posedge clk_i);
		chk("prot gated", 32'h0, 32'(eo));
		bus(1'b1, wsg_pkg::REG_CTRL, 32'h3);
		pulse_prot(1'b0); wait_bit(1, 1'b1); wait_bit(1, 1'b0); settle();
		chk("pos prot open", 32'(wsg_pkg::POS_OPEN), 32'(pos));
		pulse_prot(1'b1); wait_bit(0, 1'b1); wait_bit(0, 1'b0); settle();
		chk("pos prot close", 32'(wsg_pkg::POS_CLOSED), 32'(pos));
		rm_in <= 1'b1;
		rdy <= 1'b0;
		repeat (8) @(posedge clk_i);
		chk("removed", 32'h1, 32'(removed));
		chk("pos removed", 32'(wsg_pkg::POS_OPEN), 32'(pos));
		bus(1'b0, wsg_pkg::REG_STATUS, 32'h0); chk("status removed", 32'h0000_012D, q);
		// Override enable with closed value must not reach a removed element
		bus(1'b1, wsg_pkg::REG_CTRL, 32'h19); repeat (8) @(posedge clk_i);
		chk("pos override", 32'(wsg_pkg::POS_OPEN), 32'(pos));
		bus(1'b0, wsg_pkg::REG_IRQ_STAT, 32'h0); chk("stat removed", 32'h1, 32'(q[4]));
		chk("irq masked", 32'h0, 32'(irq));
		bus(1'b1, wsg_pkg::REG_IRQ_EN, 32'h1F); settle(); chk("irq on", 32'h1, 32'(irq));
		bus(1'b1, wsg_pkg::REG_IRQ_EN, 32'h0); settle(); chk("irq off", 32'h0, 32'(irq));
		bus(1'b1, wsg_pkg::REG_IRQ_EN, 32'h1F);
		bus(1'b1, wsg_pkg::REG_IRQ_CLR, 32'h1F); settle(); chk("irq clr", 32'h0, 32'(irq));
		bus(1'b0, wsg_pkg::REG_IRQ_STAT, 32'h0); chk("stat clr", 32'h0, q);
		give_verdict();
	end
endmodule
`default_nettype wire

// >>> hdl/wsg_channel.sv
// One switchgear channel: position validation and command pulse timing
`timescale 1ns/100ps
`default_nettype none
module wsg_channel (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic tick_i,
	input wire logic aux_closed_i,
	input wire logic aux_open_i,
	input wire logic cmd_close_i,
	input wire logic cmd_open_i,
	input wire logic dwell_en_i,
	input wire logic [7:0] t_close_i,
	input wire logic [7:0] t_open_i,
	input wire logic [7:0] t_dwell_i,
	output logic [1:0] pos_o,
	output logic close_out_o,
	output logic open_out_o,
	output logic done_o,
	output logic disturb_o
);
	typedef enum logic [3:0] {
		WSG_IDLE = 4'h1,
		WSG_MOVE = 4'h2,
		WSG_DWELL = 4'h4,
		WSG_FAIL = 4'h8
	} wsg_state_t;

	wsg_state_t state_q;
	logic [7:0] cnt_q;
	logic dir_close_q;
	logic [1:0] static_pos;
	logic reached;

	always_comb begin
		unique case ({aux_closed_i, aux_open_i})
			2'b10: static_pos = wsg_pkg::POS_CLOSED;
			2'b01: static_pos = wsg_pkg::POS_OPEN;
			default: static_pos = wsg_pkg::POS_DISTURB;
		endcase
	end
	assign reached = dir_close_q ? (static_pos == wsg_pkg::POS_CLOSED)
		: (static_pos == wsg_pkg::POS_OPEN);

	// New command restarts the counter; end position clears it, expiry loads the dwell time
	always_ff @(posedge clk_i) begin
		done_o <= 1'b0;
		disturb_o <= 1'b0;
		if (rst_i) begin
			state_q <= WSG_IDLE;
			cnt_q <= 8'h00;
			dir_close_q <= 1'b0;
		end else if (cmd_close_i || cmd_open_i) begin
			state_q <= WSG_MOVE;
			dir_close_q <= cmd_close_i;
			cnt_q <= cmd_close_i ? t_close_i : t_open_i;
		end else begin
			unique case (state_q)
				WSG_MOVE: begin
					if (reached) begin
						state_q <= WSG_IDLE;
						cnt_q <= 8'h00;
						done_o <= 1'b1;
					end else if (cnt_q == 8'h00) begin
						state_q <= (dwell_en_i && t_dwell_i != 8'h00) ? WSG_DWELL : WSG_FAIL;
						cnt_q <= t_dwell_i;
						// Any path into the fault state raises the disturbed event
						disturb_o <= !(dwell_en_i && t_dwell_i != 8'h00);
					end else if (tick_i) begin
						cnt_q <= cnt_q - 8'h01;
					end
				end
				WSG_DWELL: begin
					if (cnt_q == 8'h00) begin
						state_q <= WSG_IDLE;
					end else if (tick_i) begin
						cnt_q <= cnt_q - 8'h01;
					end
				end
				WSG_FAIL: begin
					// Fault holds until a clean end position appears or a new command arrives
					if (static_pos != wsg_pkg::POS_DISTURB) begin
						state_q <= WSG_IDLE;
					end
				end
				default: state_q <= WSG_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pos_o <= wsg_pkg::POS_INDETERM;
		end else begin
			unique case (state_q)
				WSG_MOVE: pos_o <= reached ? static_pos : wsg_pkg::POS_INDETERM;
				WSG_DWELL: pos_o <= wsg_pkg::POS_INDETERM;
				WSG_FAIL: pos_o <= wsg_pkg::POS_DISTURB;
				default: pos_o <= static_pos;
			endcase
		end
	end

	// Pulse never outlasts the moving time and drops on feedback
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			close_out_o <= 1'b0;
			open_out_o <= 1'b0;
		end else begin
			close_out_o <= (cmd_close_i || (state_q == WSG_MOVE && dir_close_q && !reached
				&& cnt_q != 8'h00));
			open_out_o <= (cmd_open_i && !cmd_close_i) || (state_q == WSG_MOVE
				&& !dir_close_q && !reached && cnt_q != 8'h00);
		end
	end
endmodule
`default_nettype wire

// >>> hdl/wsg_pkg.sv
// Package for the withdrawable switchgear supervision block
package wsg_pkg;
	// Position codes
	localparam logic [1:0] POS_INDETERM = 2'h0;
	localparam logic [1:0] POS_OPEN = 2'h1;
	localparam logic [1:0] POS_CLOSED = 2'h2;
	localparam logic [1:0] POS_DISTURB = 2'h3;
	// Register byte offsets
	localparam logic [4:0] REG_CTRL = 5'h00;
	localparam logic [4:0] REG_CMD = 5'h04;
	localparam logic [4:0] REG_STATUS = 5'h08;
	localparam logic [4:0] REG_IRQ_STAT = 5'h0C;
	localparam logic [4:0] REG_IRQ_CLR = 5'h10;
	localparam logic [4:0] REG_IRQ_EN = 5'h14;
	localparam logic [4:0] REG_ELEM_TIME = 5'h18;
	localparam logic [4:0] REG_TRUCK_TIME = 5'h1C;
	// Control fields
	localparam int CTRL_INTERLOCK = 0;
	localparam int CTRL_PROT_ROUTE = 1;
	localparam int CTRL_DWELL_EN = 2;
	localparam int CTRL_OVR_EN = 3;
	localparam int CTRL_OVR_POS = 4;
	// Command fields
	localparam int CMD_ELEM_CLOSE = 0;
	localparam int CMD_ELEM_OPEN = 1;
	localparam int CMD_TRUCK_IN = 2;
	localparam int CMD_TRUCK_OUT = 3;
	// Time fields: move-close, move-open, dwell, 8 bits each in ticks
	localparam int TIME_W = 8;
	localparam int TIME_CLOSE_LSB = 0;
	localparam int TIME_OPEN_LSB = 8;
	localparam int TIME_DWELL_LSB = 16;
	localparam logic [7:0] TIME_CLOSE_RST = 8'h0A;
	localparam logic [7:0] TIME_OPEN_RST = 8'h0A;
	localparam logic [7:0] TIME_DWELL_RST = 8'h00;
	// Timer tick of 1 ms
	localparam int CLK_HZ = 50000000;
	localparam int TICK_US = 1000;
	localparam int TICK_CYC = CLK_HZ / 1000000 * TICK_US;
	// Interrupt events
	localparam int IRQ_W = 5;
	localparam int EV_ELEM_DONE = 0;
	localparam int EV_ELEM_DISTURB = 1;
	localparam int EV_TRUCK_DONE = 2;
	localparam int EV_TRUCK_DISTURB = 3;
	localparam int EV_REMOVED = 4;
	localparam logic [31:0] BUS_ZERO = 32'h0000_0000;
endpackage

// >>> hdl/wsg_top.sv
// Withdrawable switchgear supervision with Wishbone register access
//
// Summary of operation
// - Positions coded 0 indeterminate, 1 open, 2 closed, 3 disturbed.
// - Indeterminate while moving timer runs; disturbed if it expires without feedback, unless dwell is enabled with a nonzero dwell time.
// - Withdrawable object is two channels: switching element and movable truck.
// - One combined position code for both channels, plus a removed flag.
// - Removed flag is set while the plug input reports removal.
// - While removed, element position reads open whatever its contacts say.
// - Position override is refused while the element is removed.
// - Truck withdraw blocked while element closed, only when interlock set.
// - Element commands accepted with truck withdrawn or inserted.
// - Element takes closed, open, ready, removed; truck only closed and open.
// - Earthing part takes only earthed and open contacts.
// - Element and truck channels each hold their own close, open and dwell times.
// - Same moving times judge position and bound command pulses.
// - Close pulse lasts at most close moving time, ends on closed.
// - Open pulse lasts at most open moving time, ends on open.
// - Protection commands optionally routed onto the control relays.
`timescale 1ns/100ps
`default_nettype none
module wsg_top (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [4:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_we_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic elem_aux_closed_i,
	input wire logic elem_aux_open_i,
	input wire logic elem_ready_i,
	input wire logic elem_removed_i,
	input wire logic truck_aux_closed_i,
	input wire logic truck_aux_open_i,
	input wire logic earth_aux_earthed_i,
	input wire logic earth_aux_open_i,
	input wire logic prot_close_i,
	input wire logic prot_open_i,
	output logic [1:0] pos_o,
	output logic removed_o,
	output logic [1:0] earth_pos_o,
	output logic elem_close_o,
	output logic elem_open_o,
	output logic truck_in_o,
	output logic truck_out_o,
	output logic irq_o
);
	localparam int NPIN = 8;

	logic [NPIN-1:0] pin_raw;
	logic [NPIN-1:0] sync1_q;
	logic [NPIN-1:0] sync2_q;
	logic [31:0] ctrl_q;
	logic [31:0] elem_time_q;
	logic [31:0] truck_time_q;
	logic [3:0] cmd_q;
	logic [wsg_pkg::IRQ_W-1:0] irq_stat_q;
	logic [wsg_pkg::IRQ_W-1:0] irq_en_q;
	logic [15:0] tick_cnt_q;
	logic tick_q;
	logic removed_prev_q;
	logic wb_req;
	logic wb_wr;
	logic [31:0] wmask;

	logic e_aux_c, e_aux_o, e_ready, e_rem, t_aux_c, t_aux_o, g_aux_e, g_aux_o;
	logic [1:0] elem_pos, truck_pos, earth_pos, elem_pos_eff;
	logic elem_close, elem_open, truck_in, truck_out;
	logic elem_done, elem_dist, truck_done, truck_dist;
	logic elem_cmd_c, elem_cmd_o, truck_cmd_i, truck_cmd_o, earth_cmd_unused;
	logic [wsg_pkg::IRQ_W-1:0] events;

	// Contact and plug pins pass two flops before use; protection inputs are used directly
	assign pin_raw = {earth_aux_open_i, earth_aux_earthed_i, truck_aux_open_i,
		truck_aux_closed_i, elem_removed_i, elem_ready_i, elem_aux_open_i, elem_aux_closed_i};
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else begin
			sync1_q <= pin_raw;
			sync2_q <= sync1_q;
		end
	end
	assign {g_aux_o, g_aux_e, t_aux_o, t_aux_c, e_rem, e_ready, e_aux_o, e_aux_c} = sync2_q;

	// Timer tick
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tick_cnt_q <= 16'h0000;
			tick_q <= 1'b0;
		end else if (tick_cnt_q == 16'(wsg_pkg::TICK_CYC - 1)) begin
			tick_cnt_q <= 16'h0000;
			tick_q <= 1'b1;
		end else begin
			tick_cnt_q <= tick_cnt_q + 16'h0001;
			tick_q <= 1'b0;
		end
	end

	// Wishbone classic: one-cycle ack, request sampled when ack is low
	assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wb_wr = wb_req && wb_we_i;
	generate
		for (genvar b = 0; b < 4; b++) begin : g_mask
			assign wmask[8*b+7:8*b] = {8{wb_sel_i[b]}};
		end
	endgenerate

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= wb_req;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= wsg_pkg::BUS_ZERO;
		end else if (wb_req && !wb_we_i) begin
			unique case (wb_adr_i)
				wsg_pkg::REG_CTRL: wb_dat_o <= ctrl_q;
				wsg_pkg::REG_STATUS: wb_dat_o <= {22'h0, e_ready, earth_pos_o, truck_pos,
					elem_pos_eff, removed_o, pos_o};
				wsg_pkg::REG_IRQ_STAT: wb_dat_o <= {27'h0, irq_stat_q};
				wsg_pkg::REG_IRQ_EN: wb_dat_o <= {27'h0, irq_en_q};
				wsg_pkg::REG_ELEM_TIME: wb_dat_o <= elem_time_q;
				wsg_pkg::REG_TRUCK_TIME: wb_dat_o <= truck_time_q;
				default: wb_dat_o <= wsg_pkg::BUS_ZERO;
			endcase
		end
	end

	// Configuration registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_q <= wsg_pkg::BUS_ZERO;
			elem_time_q <= {8'h00, wsg_pkg::TIME_DWELL_RST, wsg_pkg::TIME_OPEN_RST,
				wsg_pkg::TIME_CLOSE_RST};
			truck_time_q <= {8'h00, wsg_pkg::TIME_DWELL_RST, wsg_pkg::TIME_OPEN_RST,
				wsg_pkg::TIME_CLOSE_RST};
			irq_en_q <= '0;
		end else if (wb_wr) begin
			if (wb_adr_i == wsg_pkg::REG_CTRL) begin
				ctrl_q <= (ctrl_q & ~wmask) | (wb_dat_i & wmask & 32'h0000_001F);
			end
			if (wb_adr_i == wsg_pkg::REG_ELEM_TIME) begin
				elem_time_q <= (elem_time_q & ~wmask) | (wb_dat_i & wmask & 32'h00FF_FFFF);
			end
			if (wb_adr_i == wsg_pkg::REG_TRUCK_TIME) begin
				truck_time_q <= (truck_time_q & ~wmask) | (wb_dat_i & wmask & 32'h00FF_FFFF);
			end
			if (wb_adr_i == wsg_pkg::REG_IRQ_EN && wb_sel_i[0]) begin
				irq_en_q <= wb_dat_i[wsg_pkg::IRQ_W-1:0];
			end
		end
	end

	// Command strobes, one cycle each
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cmd_q <= 4'h0;
		end else if (wb_wr && wb_adr_i == wsg_pkg::REG_CMD && wb_sel_i[0]) begin
			cmd_q <= wb_dat_i[3:0];
		end else begin
			cmd_q <= 4'h0;
		end
	end

	// Element commands work regardless of truck position
	assign elem_cmd_c = cmd_q[wsg_pkg::CMD_ELEM_CLOSE] ||
		(ctrl_q[wsg_pkg::CTRL_PROT_ROUTE] && prot_close_i);
	assign elem_cmd_o = !elem_cmd_c && (cmd_q[wsg_pkg::CMD_ELEM_OPEN] ||
		(ctrl_q[wsg_pkg::CTRL_PROT_ROUTE] && prot_open_i));
	assign truck_cmd_i = cmd_q[wsg_pkg::CMD_TRUCK_IN];
	// Truck withdraw blocked when insert is also set, or when interlock enabled and element closed
	assign truck_cmd_o = !truck_cmd_i && cmd_q[wsg_pkg::CMD_TRUCK_OUT] &&
		!(ctrl_q[wsg_pkg::CTRL_INTERLOCK] && elem_pos_eff == wsg_pkg::POS_CLOSED);

	// Switching element: closed, open contacts; ready and removed handled here
	wsg_channel u_elem (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.tick_i(tick_q),
		.aux_closed_i(e_aux_c),
		.aux_open_i(e_aux_o),
		.cmd_close_i(elem_cmd_c),
		.cmd_open_i(elem_cmd_o),
		.dwell_en_i(ctrl_q[wsg_pkg::CTRL_DWELL_EN]),
		.t_close_i(elem_time_q[wsg_pkg::TIME_CLOSE_LSB +: wsg_pkg::TIME_W]),
		.t_open_i(elem_time_q[wsg_pkg::TIME_OPEN_LSB +: wsg_pkg::TIME_W]),
		.t_dwell_i(elem_time_q[wsg_pkg::TIME_DWELL_LSB +: wsg_pkg::TIME_W]),
		.pos_o(elem_pos),
		.close_out_o(elem_close),
		.open_out_o(elem_open),
		.done_o(elem_done),
		.disturb_o(elem_dist)
	);

	// Truck: closed and open contacts only
	wsg_channel u_truck (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.tick_i(tick_q),
		.aux_closed_i(t_aux_c),
		.aux_open_i(t_aux_o),
		.cmd_close_i(truck_cmd_i),
		.cmd_open_i(truck_cmd_o),
		.dwell_en_i(ctrl_q[wsg_pkg::CTRL_DWELL_EN]),
		.t_close_i(truck_time_q[wsg_pkg::TIME_CLOSE_LSB +: wsg_pkg::TIME_W]),
		.t_open_i(truck_time_q[wsg_pkg::TIME_OPEN_LSB +: wsg_pkg::TIME_W]),
		.t_dwell_i(truck_time_q[wsg_pkg::TIME_DWELL_LSB +: wsg_pkg::TIME_W]),
		.pos_o(truck_pos),
		.close_out_o(truck_in),
		.open_out_o(truck_out),
		.done_o(truck_done),
		.disturb_o(truck_dist)
	);

	// Earthing part: earthed and open contacts only, no commands here
	assign earth_cmd_unused = 1'b0;
	wsg_channel u_earth (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.tick_i(tick_q),
		.aux_closed_i(g_aux_e),
		.aux_open_i(g_aux_o),
		.cmd_close_i(earth_cmd_unused),
		.cmd_open_i(earth_cmd_unused),
		.dwell_en_i(earth_cmd_unused),
		.t_close_i(wsg_pkg::TIME_CLOSE_RST),
		.t_open_i(wsg_pkg::TIME_OPEN_RST),
		.t_dwell_i(wsg_pkg::TIME_DWELL_RST),
		.pos_o(earth_pos),
		.close_out_o(),
		.open_out_o(),
		.done_o(),
		.disturb_o()
	);

	// Removed forces open; override only honoured while not removed
	always_comb begin
		if (e_rem) begin
			elem_pos_eff = wsg_pkg::POS_OPEN;
		end else if (ctrl_q[wsg_pkg::CTRL_OVR_EN]) begin
			elem_pos_eff = ctrl_q[wsg_pkg::CTRL_OVR_POS] ? wsg_pkg::POS_CLOSED : wsg_pkg::POS_OPEN;
		end else begin
			elem_pos_eff = elem_pos;
		end
	end

	// Combined code: a moving or faulty element or truck channel dominates, else element position
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pos_o <= wsg_pkg::POS_INDETERM;
			removed_o <= 1'b0;
			earth_pos_o <= wsg_pkg::POS_INDETERM;
		end else begin
			removed_o <= e_rem;
			earth_pos_o <= earth_pos;
			if (elem_pos_eff == wsg_pkg::POS_DISTURB || truck_pos == wsg_pkg::POS_DISTURB) begin
				pos_o <= wsg_pkg::POS_DISTURB;
			end else if (elem_pos_eff == wsg_pkg::POS_INDETERM
				|| truck_pos == wsg_pkg::POS_INDETERM) begin
				pos_o <= wsg_pkg::POS_INDETERM;
			end else begin
				pos_o <= elem_pos_eff;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			elem_close_o <= 1'b0;
			elem_open_o <= 1'b0;
			truck_in_o <= 1'b0;
			truck_out_o <= 1'b0;
		end else begin
			elem_close_o <= elem_close;
			elem_open_o <= elem_open;
			truck_in_o <= truck_in;
			truck_out_o <= truck_out;
		end
	end

	// Sticky events; a new event beats a clear in the same cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			removed_prev_q <= 1'b0;
		end else begin
			removed_prev_q <= e_rem;
		end
	end
	assign events = {e_rem && !removed_prev_q, truck_dist, truck_done, elem_dist, elem_done};

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_stat_q <= '0;
			irq_o <= 1'b0;
		end else begin
			if (wb_wr && wb_adr_i == wsg_pkg::REG_IRQ_CLR && wb_sel_i[0]) begin
				irq_stat_q <= (irq_stat_q & ~wb_dat_i[wsg_pkg::IRQ_W-1:0]) | events;
			end else begin
				irq_stat_q <= irq_stat_q | events;
			end
			irq_o <= |(irq_stat_q & irq_en_q);
		end
	end
endmodule
`default_nettype wire
